// [hw/wcp_pkg.sv]
// Constants for the watchdog configuration-port block.
// Assumes a 100 MHz pclk and a host that reaches the I/O ports over APB.
package wcp_pkg;
    // I/O ports as register indices; byte address is four times the index
    localparam logic [9:0] IO_INDEX_PRI = 10'h02e;
    localparam logic [9:0] IO_DATA_PRI = 10'h02f;
    localparam logic [9:0] IO_INDEX_ALT = 10'h04e;
    localparam logic [9:0] IO_DATA_ALT = 10'h04f;
    // Block's own APB registers (word indices)
    localparam logic [9:0] IDX_IRQ_STS = 10'h080;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h081;
    localparam logic [9:0] IDX_STATUS = 10'h082;
    // Keys
    localparam logic [7:0] UNLOCK_KEY = 8'h87;
    localparam logic [7:0] LOCK_KEY = 8'haa;
    // Configuration space
    localparam logic [7:0] CFG_LDN = 8'h07;
    localparam logic [7:0] CFG_LD_FIRST = 8'h30;
    localparam logic [7:0] LDN_WDT = 8'h07;
    localparam logic [7:0] WDT_EN_REG = 8'h30;
    localparam logic [7:0] WDT_UNIT_REG = 8'hf5;
    localparam logic [7:0] WDT_CNT_REG = 8'hf6;
    localparam logic [7:0] WDT_WAKE_REG = 8'hfa;
    localparam int WDT_EN_BIT = 0;
    localparam int UNIT_MIN_BIT = 3;
    localparam int UNIT_STS_BIT = 6;
    localparam logic [7:0] IDLE_READ = 8'hff;
    // Reset values
    localparam logic [7:0] LDN_RST = 8'h00;
    localparam logic [7:0] UNIT_RST = 8'h00;
    localparam logic [7:0] WAKE_RST = 8'h00;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    // Interrupt bits
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_UNLOCK = 1;
    localparam int IRQ_EXIT = 2;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ONE_SEC_NS = 1_000_000_000;
    localparam int CYC_PER_SEC = ONE_SEC_NS / CLK_PERIOD_NS;
    localparam int SEC_PER_MIN = 60;
    localparam int RST_PULSE_NS = 160;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_LOCKED = 3'b001,
        ST_HALF = 3'b010,
        ST_CONFIG = 3'b100
    } wcp_state_t;
endpackage

// [hw/wcp_timebase.sv]
// Second and minute tick divider for the watchdog countdown.
// Assumes run is a level from the same clock domain.
`timescale 1ns/1ps
module wcp_timebase #(
    parameter int CYC_PER_SEC = wcp_pkg::CYC_PER_SEC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic restart,
    // Ticks
    output logic sec_tick,
    output logic min_tick
);
    localparam int CW = $clog2(CYC_PER_SEC + 1);
    localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_SEC - 1);
    localparam logic [5:0] SEC_LAST = 6'(wcp_pkg::SEC_PER_MIN - 1);

    logic [CW-1:0] cyc;
    logic [CW-1:0] next_cyc;
    logic [5:0] secs;
    logic [5:0] next_secs;

    // Counters restart while idle so the first unit is whole
    always_comb begin
        next_cyc = cyc;
        next_secs = secs;
        sec_tick = 1'b0;
        min_tick = 1'b0;
        if (!run || restart) begin
            next_cyc = '0;
            next_secs = '0;
        end else if (cyc == CYC_LAST) begin
            next_cyc = '0;
            sec_tick = 1'b1;
            if (secs == SEC_LAST) begin
                next_secs = '0;
                min_tick = 1'b1;
            end else begin
                next_secs = secs + 6'h01;
            end
        end else begin
            next_cyc = cyc + CW'(1);
        end
    end

    // Register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc <= '0;
            secs <= '0;
        end else begin
            cyc <= next_cyc;
            secs <= next_secs;
        end
    end
endmodule

// [hw/wcp_top.sv]
// Configuration-port front end with watchdog logical device.
// Assumes host I/O cycles arrive as APB transfers on the same pclk.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module wcp_top #(
    parameter int CYC_PER_SEC = wcp_pkg::CYC_PER_SEC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Watchdog and interrupt
    output logic wdt_timeout,
    output logic irq
);
    wcp_pkg::wcp_state_t state;
    wcp_pkg::wcp_state_t next_state;
    logic cfg_alt, next_cfg_alt;
    logic [7:0] cfg_index_reg, next_cfg_index_reg;
    logic [7:0] ldn, next_ldn;
    logic wdt_en, next_wdt_en;
    logic [7:0] wdt_unit, next_wdt_unit;
    logic [7:0] wdt_wake, next_wdt_wake;
    logic [7:0] wdt_cnt, next_wdt_cnt;
    logic [4:0] rst_cnt, next_rst_cnt;
    logic next_wdt_timeout;
    logic [2:0] irq_sts, next_irq_sts;
    logic [2:0] irq_mask, next_irq_mask;
    logic [31:0] next_prdata;
    logic sec_tick, min_tick;
    logic [9:0] word;
    logic wr_acc, rd_setup, cfg_mode;
    logic on_idx, on_data, any_port, mapped;
    logic cfg_wr_idx, cfg_wr_data, sel_wdt, cnt_load, timeout_ev;
    logic [7:0] wbyte;

    // Access decode
    assign word = paddr[11:2];
    assign wbyte = pwdata[7:0];
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign cfg_mode = (state == wcp_pkg::ST_CONFIG);
    assign on_idx = word == (cfg_alt ? wcp_pkg::IO_INDEX_ALT : wcp_pkg::IO_INDEX_PRI);
    assign on_data = word == (cfg_alt ? wcp_pkg::IO_DATA_ALT : wcp_pkg::IO_DATA_PRI);
    assign any_port = is_unlock_port(word) || word == wcp_pkg::IO_DATA_PRI
        || word == wcp_pkg::IO_DATA_ALT;
    assign mapped = any_port || word == wcp_pkg::IDX_IRQ_STS
        || word == wcp_pkg::IDX_IRQ_MASK || word == wcp_pkg::IDX_STATUS;
    assign cfg_wr_idx = wr_acc && cfg_mode && on_idx && wbyte != wcp_pkg::LOCK_KEY;
    assign cfg_wr_data = wr_acc && cfg_mode && on_data;
    assign sel_wdt = (ldn == wcp_pkg::LDN_WDT);
    assign cnt_load = cfg_wr_data && sel_wdt && cfg_index_reg == wcp_pkg::WDT_CNT_REG;
    assign timeout_ev = wdt_en && !cnt_load && wdt_cnt == 8'h01
        && (wdt_unit[wcp_pkg::UNIT_MIN_BIT] ? min_tick : sec_tick);
    // Zero-wait slave, error on unmapped word
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign irq = |(irq_sts & irq_mask);

    // True for either unlock/index port
    function automatic logic is_unlock_port(input logic [9:0] w);
        is_unlock_port = (w == wcp_pkg::IO_INDEX_PRI) || (w == wcp_pkg::IO_INDEX_ALT);
    endfunction

    // Configuration register read
    function automatic logic [7:0] cfg_read(input logic [7:0] idx, input logic wdt);
        cfg_read = 8'h00;
        if (idx == wcp_pkg::CFG_LDN) begin
            cfg_read = ldn;
        end else if (idx >= wcp_pkg::CFG_LD_FIRST && wdt) begin
            unique case (idx)
                wcp_pkg::WDT_EN_REG: cfg_read = {7'h00, wdt_en};
                wcp_pkg::WDT_UNIT_REG: cfg_read = wdt_unit;
                wcp_pkg::WDT_CNT_REG: cfg_read = wdt_cnt;
                wcp_pkg::WDT_WAKE_REG: cfg_read = wdt_wake;
                default: cfg_read = 8'h00;
            endcase
        end
    endfunction

    wcp_timebase #(
        .CYC_PER_SEC(CYC_PER_SEC)
    ) u_timebase (
        .pclk(pclk),
        .presetn(presetn),
        .run(wdt_en && wdt_cnt != 8'h00),
        .restart(cnt_load),
        .sec_tick(sec_tick),
        .min_tick(min_tick)
    );

    // Unlock sequence and configuration index
    always_comb begin
        next_state = state;
        next_cfg_alt = cfg_alt;
        next_cfg_index_reg = cfg_index_reg;
        if (wr_acc && any_port) begin
            unique case (state)
                wcp_pkg::ST_LOCKED: begin
                    if (is_unlock_port(word) && wbyte == wcp_pkg::UNLOCK_KEY) begin
                        next_state = wcp_pkg::ST_HALF;
                        next_cfg_alt = (word == wcp_pkg::IO_INDEX_ALT);
                    end
                end
                wcp_pkg::ST_HALF: begin
                    if (on_idx && wbyte == wcp_pkg::UNLOCK_KEY) begin
                        next_state = wcp_pkg::ST_CONFIG;
                    end else if (is_unlock_port(word) && wbyte == wcp_pkg::UNLOCK_KEY) begin
                        next_cfg_alt = (word == wcp_pkg::IO_INDEX_ALT);
                    end else begin
                        next_state = wcp_pkg::ST_LOCKED;
                    end
                end
                wcp_pkg::ST_CONFIG: begin
                    if (on_idx && wbyte == wcp_pkg::LOCK_KEY) begin
                        next_state = wcp_pkg::ST_LOCKED;
                    end else if (cfg_wr_idx) begin
                        next_cfg_index_reg = wbyte;
                    end
                end
            endcase
        end
    end

    // Configuration and watchdog registers
    always_comb begin
        next_ldn = ldn;
        next_wdt_en = wdt_en;
        next_wdt_unit = wdt_unit;
        next_wdt_wake = wdt_wake;
        next_wdt_cnt = wdt_cnt;
        if (cfg_wr_data) begin
            if (cfg_index_reg == wcp_pkg::CFG_LDN) begin
                next_ldn = wbyte;
            end else if (cfg_index_reg >= wcp_pkg::CFG_LD_FIRST && sel_wdt) begin
                if (cfg_index_reg == wcp_pkg::WDT_EN_REG) begin
                    next_wdt_en = wbyte[wcp_pkg::WDT_EN_BIT];
                end
                if (cfg_index_reg == wcp_pkg::WDT_UNIT_REG) begin
                    // unit select, status bit is write-one-clear
                    next_wdt_unit = wbyte;
                    next_wdt_unit[wcp_pkg::UNIT_STS_BIT] =
                        wdt_unit[wcp_pkg::UNIT_STS_BIT] && !wbyte[wcp_pkg::UNIT_STS_BIT];
                end
                if (cfg_index_reg == wcp_pkg::WDT_WAKE_REG) begin
                    next_wdt_wake = wbyte;
                end
            end
        end
        if (cnt_load) begin
            next_wdt_cnt = wbyte;
        end else if (wdt_en && wdt_cnt != 8'h00
                     && (wdt_unit[wcp_pkg::UNIT_MIN_BIT] ? min_tick : sec_tick)) begin
            next_wdt_cnt = wdt_cnt - 8'h01;
        end
        if (timeout_ev) begin
            next_wdt_unit[wcp_pkg::UNIT_STS_BIT] = 1'b1;
        end
    end

    // Timeout pulse and interrupts
    always_comb begin
        next_rst_cnt = rst_cnt;
        if (timeout_ev) begin
            next_rst_cnt = 5'(wcp_pkg::RST_PULSE_CYC);
        end else if (rst_cnt != 5'h00) begin
            next_rst_cnt = rst_cnt - 5'h01;
        end
        next_wdt_timeout = (next_rst_cnt != 5'h00);
        next_irq_mask = irq_mask;
        next_irq_sts = irq_sts;
        if (wr_acc && word == wcp_pkg::IDX_IRQ_MASK) begin
            next_irq_mask = pwdata[2:0];
        end
        if (wr_acc && word == wcp_pkg::IDX_IRQ_STS) begin
            next_irq_sts = irq_sts & ~pwdata[2:0];
        end
        next_irq_sts[wcp_pkg::IRQ_TIMEOUT] = next_irq_sts[wcp_pkg::IRQ_TIMEOUT] | timeout_ev;
        next_irq_sts[wcp_pkg::IRQ_UNLOCK] = next_irq_sts[wcp_pkg::IRQ_UNLOCK]
            | (state == wcp_pkg::ST_HALF && next_state == wcp_pkg::ST_CONFIG);
        next_irq_sts[wcp_pkg::IRQ_EXIT] = next_irq_sts[wcp_pkg::IRQ_EXIT]
            | (cfg_mode && next_state == wcp_pkg::ST_LOCKED);
    end

    // Read data captured in the setup cycle
    always_comb begin
        next_prdata = prdata;
        if (rd_setup) begin
            next_prdata = 32'h0000_0000;
            if (any_port) begin
                next_prdata[7:0] = wcp_pkg::IDLE_READ;
                if (cfg_mode && on_idx) begin
                    next_prdata[7:0] = cfg_index_reg;
                end else if (cfg_mode && on_data) begin
                    next_prdata[7:0] = cfg_read(cfg_index_reg, sel_wdt);
                end
            end else if (word == wcp_pkg::IDX_IRQ_STS) begin
                next_prdata[2:0] = irq_sts;
            end else if (word == wcp_pkg::IDX_IRQ_MASK) begin
                next_prdata[2:0] = irq_mask;
            end else if (word == wcp_pkg::IDX_STATUS) begin
                next_prdata[15:0] = {3'h0, wdt_timeout, state, wdt_en, wdt_cnt};
            end
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= wcp_pkg::ST_LOCKED;
            cfg_alt <= 1'b0;
            cfg_index_reg <= 8'h00;
            ldn <= wcp_pkg::LDN_RST;
            wdt_en <= 1'b0;
            wdt_unit <= wcp_pkg::UNIT_RST;
            wdt_wake <= wcp_pkg::WAKE_RST;
            wdt_cnt <= 8'h00;
            rst_cnt <= 5'h00;
            wdt_timeout <= 1'b0;
            irq_sts <= 3'h0;
            irq_mask <= wcp_pkg::IRQ_MASK_RST;
            prdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            cfg_alt <= next_cfg_alt;
            cfg_index_reg <= next_cfg_index_reg;
            ldn <= next_ldn;
            wdt_en <= next_wdt_en;
            wdt_unit <= next_wdt_unit;
            wdt_wake <= next_wdt_wake;
            wdt_cnt <= next_wdt_cnt;
            rst_cnt <= next_rst_cnt;
            wdt_timeout <= next_wdt_timeout;
            irq_sts <= next_irq_sts;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
        end
    end

    // Checks
    a_unlock_two_keys: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cfg_mode) |-> $past(state) == wcp_pkg::ST_HALF
            && $past(wbyte) == wcp_pkg::UNLOCK_KEY)
        else $error("config entered without second key");
    a_exit_key_locks: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_mode && wr_acc && on_idx && wbyte == wcp_pkg::LOCK_KEY
            |=> state == wcp_pkg::ST_LOCKED ##1 !cfg_mode)
        else $error("exit key did not lock");
    a_locked_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_mode |=> $stable(ldn) && $stable(wdt_en) && $stable(cfg_index_reg))
        else $error("locked write changed a register");
    a_index_write: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr_idx |=> cfg_index_reg == $past(wbyte))
        else $error("index port write lost");
    a_ldn_select: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr_data && cfg_index_reg == wcp_pkg::CFG_LDN |=> ldn == $past(wbyte))
        else $error("device select not taken");
    a_wdt_enable: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr_data && sel_wdt && cfg_index_reg == wcp_pkg::WDT_EN_REG
            |=> wdt_en == $past(pwdata[0]))
        else $error("watchdog enable not taken");
    a_unit_seconds: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr_data && sel_wdt && cfg_index_reg == wcp_pkg::WDT_UNIT_REG
            && !wbyte[wcp_pkg::UNIT_MIN_BIT] |=> !wdt_unit[wcp_pkg::UNIT_MIN_BIT])
        else $error("unit not set to seconds");
    a_count_load: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_load |=> wdt_cnt == $past(wbyte))
        else $error("count load failed");
    a_timeout_flag: assert property (@(posedge pclk) disable iff (!presetn)
        timeout_ev |=> wdt_timeout && wdt_unit[wcp_pkg::UNIT_STS_BIT]
            && wdt_cnt == 8'h00 && irq_sts[wcp_pkg::IRQ_TIMEOUT])
        else $error("timeout not signalled");
    a_locked_read_idle: assert property (@(posedge pclk) disable iff (!presetn)
        rd_setup && any_port && !cfg_mode |=> prdata[7:0] == wcp_pkg::IDLE_READ)
        else $error("locked port read not idle");
    a_other_dev_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr_data && !sel_wdt && cfg_index_reg >= wcp_pkg::CFG_LD_FIRST
            |=> $stable(wdt_en) && $stable(wdt_unit[wcp_pkg::UNIT_MIN_BIT]))
        else $error("write reached watchdog while unselected");
    c_unlock: cover property (@(posedge pclk) disable iff (!presetn) $rose(cfg_mode));
    c_minute_expiry: cover property (@(posedge pclk) disable iff (!presetn)
        timeout_ev && wdt_unit[wcp_pkg::UNIT_MIN_BIT]);
    c_relock: cover property (@(posedge pclk) disable iff (!presetn) $fell(cfg_mode));
    c_timeout: cover property (@(posedge pclk) disable iff (!presetn) timeout_ev);
endmodule

// [dv/wcp_host_model.sv]
// Host processor model: issues I/O port cycles as APB transfers.
// Assumes a slave on the same pclk that answers with pready.
`timescale 1ns/1ps
module wcp_host_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rd;
    logic er;

    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // One APB transfer, held until pready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        // No request while reset still holds
        while (presetn !== 1'b1) begin
            @(posedge pclk);
        end
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdata = prdata;
        err = pslverr;
        // Released lines stop showing the last value
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wdata;
    endtask

    task automatic unlock(input logic [11:0] port);
        xfer(1'b1, port, {24'h0, wcp_pkg::UNLOCK_KEY}, rd, er);
        xfer(1'b1, port, {24'h0, wcp_pkg::UNLOCK_KEY}, rd, er);
    endtask

    task automatic lock(input logic [11:0] port);
        xfer(1'b1, port, {24'h0, wcp_pkg::LOCK_KEY}, rd, er);
    endtask

    task automatic cfg_wr(input logic [11:0] port, input logic [7:0] idx, input logic [7:0] val);
        xfer(1'b1, port, {24'h0, idx}, rd, er);
        xfer(1'b1, port + 12'h004, {24'h0, val}, rd, er);
    endtask

    task automatic cfg_rd(input logic [11:0] port, input logic [7:0] idx, output logic [31:0] val);
        xfer(1'b1, port, {24'h0, idx}, rd, er);
        xfer(1'b0, port + 12'h004, 32'h0000_0000, val, er);
    endtask

    task automatic select_dev(input logic [11:0] port, input logic [7:0] ldn);
        cfg_wr(port, wcp_pkg::CFG_LDN, ldn);
    endtask
endmodule

// [dv/watchdog_config_port_tb.sv]
// Self-checking bench for the watchdog configuration-port block.
// Assumes the host model drives all APB inputs; short second for speed.
`timescale 1ns/1ps
module watchdog_config_port_tb;
    localparam int CPS = 20;
    localparam logic [11:0] A_IDX = {wcp_pkg::IO_INDEX_PRI, 2'b00};
    localparam logic [11:0] A_DAT = {wcp_pkg::IO_DATA_PRI, 2'b00};
    localparam logic [11:0] A_ALT = {wcp_pkg::IO_INDEX_ALT, 2'b00};
    localparam logic [11:0] A_STS = {wcp_pkg::IDX_IRQ_STS, 2'b00};
    localparam logic [11:0] A_MSK = {wcp_pkg::IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_ST = {wcp_pkg::IDX_STATUS, 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, wdt_timeout, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic err;
    int n_errors = 0;
    int samples_checked = 0;
    localparam int LIMIT = 5000;
    int cycles = 0;
    int n;

    // Clock
    always #5 pclk = ~pclk;

    wcp_top #(.CYC_PER_SEC(CPS)) wcp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wdt_timeout(wdt_timeout), .irq(irq));

    wcp_host_model wcp_host_model_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register read with expectation
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        wcp_host_model_i.xfer(1'b0, a, 32'h0, v, err);
        check(v, exp);
    endtask

    // Register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wcp_host_model_i.xfer(1'b1, a, d, v, err);
    endtask

    // Settled interrupt level
    task automatic irq_chk(input logic exp);
        @(negedge pclk);
        check({31'h0, irq}, {31'h0, exp});
    endtask

    // Configuration register read with expectation
    task automatic cfg_chk(input logic [11:0] p, input logic [7:0] idx, input logic [31:0] exp);
        wcp_host_model_i.cfg_rd(p, idx, v);
        check(v, exp);
    endtask

    // Counts and verdict
    task automatic summarize();
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            $display("unexpected at %0t: cycle count %h reached limit %h", $time, cycles, LIMIT);
            summarize();
        end
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(A_ST, 32'h200);
        rd_chk(A_MSK, 32'h0);
        rd_chk(A_IDX, 32'hff);
        wr(A_IDX, 32'h07);
        wr(A_DAT, 32'h05);
        rd_chk(A_ST, 32'h200);
        wcp_host_model_i.unlock(A_IDX);
        rd_chk(A_ST, 32'h800);
        rd_chk(A_STS, 32'h2);
        irq_chk(1'b0);
        wr(A_MSK, 32'h2);
        irq_chk(1'b1);
        wr(A_STS, 32'h2);
        irq_chk(1'b0);
        cfg_chk(A_IDX, 8'h07, 32'h0);
        wcp_host_model_i.select_dev(A_IDX, wcp_pkg::LDN_WDT);
        cfg_chk(A_IDX, 8'h07, 32'h07);
        wcp_host_model_i.cfg_wr(A_IDX, 8'h30, 8'h01);
        rd_chk(A_ST, 32'h900);
        wcp_host_model_i.cfg_rd(A_IDX, 8'hf5, v);
        wcp_host_model_i.cfg_wr(A_IDX, 8'hf5, v[7:0] & 8'h30);
        cfg_chk(A_IDX, 8'hf5, 32'h0);
        wr(A_MSK, 32'h1);
        wcp_host_model_i.cfg_wr(A_IDX, 8'hf6, 8'h03);
        rd_chk(A_ST, 32'h903);
        repeat (CPS + 2) @(posedge pclk);
        rd_chk(A_ST, 32'h902);
        // Wait for expiry, then time the reset pulse
        n = 0;
        while (wdt_timeout !== 1'b1 && n < 200) begin
            @(negedge pclk);
            n++;
        end
        check({31'h0, wdt_timeout}, 32'h1);
        n = 0;
        while (wdt_timeout === 1'b1 && n < 40) begin
            @(negedge pclk);
            n++;
        end
        check(n, 32'(wcp_pkg::RST_PULSE_CYC));
        irq_chk(1'b1);
        rd_chk(A_STS, 32'h1);
        cfg_chk(A_IDX, 8'hf5, 32'h40);
        rd_chk(A_ST, 32'h900);
        wr(A_STS, 32'h1);
        irq_chk(1'b0);
        wcp_host_model_i.lock(A_IDX);
        rd_chk(A_ST, 32'h300);
        rd_chk(A_DAT, 32'hff);
        rd_chk(A_STS, 32'h4);
        wcp_host_model_i.unlock(A_ALT);
        rd_chk(A_ST, 32'h900);
        cfg_chk(A_ALT, 8'h07, 32'h07);
        wcp_host_model_i.lock(A_ALT);
        wr(A_IDX, 32'h87);
        wr(A_DAT, 32'h00);
        wr(A_IDX, 32'h87);
        rd_chk(A_ST, 32'h500);
        wr(A_IDX, 32'h87);
        rd_chk(A_ST, 32'h900);
        // Another device selected: watchdog registers out of reach
        wcp_host_model_i.select_dev(A_IDX, 8'h05);
        wcp_host_model_i.cfg_wr(A_IDX, 8'h30, 8'h00);
        cfg_chk(A_IDX, 8'h30, 32'h0);
        rd_chk(A_ST, 32'h900);
        wcp_host_model_i.select_dev(A_IDX, wcp_pkg::LDN_WDT);
        cfg_chk(A_IDX, 8'h30, 32'h1);
        wcp_host_model_i.cfg_wr(A_IDX, 8'hfa, 8'h51);
        cfg_chk(A_IDX, 8'hfa, 32'h51);
        // Minute unit, status bit kept by zero and cleared by one
        wcp_host_model_i.cfg_wr(A_IDX, 8'hf5, 8'h08);
        cfg_chk(A_IDX, 8'hf5, 32'h48);
        wcp_host_model_i.cfg_wr(A_IDX, 8'hf5, 8'h48);
        cfg_chk(A_IDX, 8'hf5, 32'h08);
        // One count in minutes lasts sixty short seconds
        wcp_host_model_i.cfg_wr(A_IDX, 8'hf6, 8'h01);
        n = 0;
        while (wdt_timeout !== 1'b1 && n < 1300) begin
            @(negedge pclk);
            n++;
        end
        check(n, 32'(wcp_pkg::SEC_PER_MIN * CPS + 1));
        wcp_host_model_i.xfer(1'b0, 12'h300, 32'h0, v, err);
        check(v, 32'h0);
        check({31'h0, err}, 32'h1);
        summarize();
    end
endmodule
